// File: src/wdr_cfg.svh
// Constants of the watchdog and reset-cause block.
// Function
// - Cause register bits 7:4 read zero
// - Watchdog reset sets bit 3, power-on clears
// - Brown-out sets bit 2, power-on clears
// - Pin reset sets bit 1, power-on clears
// - Power-on sets bit 0, software only clears
// - Time-out sets irq flag, vector/write-one clear
// - Irq request needs global and local enable
// - Fuse and enables select the time-out mode
// - Vector clears enable and flag in combined mode
// - Unserviced first interrupt then resets on next
// - Reset-enable clear or period change needs unlock
// - Unlock clears itself after four cycles
// - Reset enable forced while watchdog cause set
// - Period field sits at bits 5 and 2:0
// - Time-out after 2048 times two-power-code ticks
// - Counter advances on slow oscillator ticks
// - Restart instruction clears the counter
// - Watchdog reset pulse lasts one clock
`ifndef WDR_CFG_SVH
`define WDR_CFG_SVH

// ****************************************************************
// Register map
// ****************************************************************
`define WDR_ADR_CTL      8'h60
`define WDR_ADR_CAUSE    8'h64

// ****************************************************************
// Field positions
// ****************************************************************
`define WDR_CTL_FLAG     7
`define WDR_CTL_IE       6
`define WDR_CTL_P3       5
`define WDR_CTL_UNLOCK   4
`define WDR_CTL_RE       3
`define WDR_CAUSE_DOG    3
`define WDR_CAUSE_BOR    2
`define WDR_CAUSE_PIN    1
`define WDR_CAUSE_POR    0

// ****************************************************************
// Reset values and timing
// ****************************************************************
`define WDR_CTL_RST      8'h00
`define WDR_CAUSE_RST    4'h0
`define WDR_UNLOCK_CYC   2'd3
`define WDR_BASE_TICKS   2048
`define WDR_PERIOD_MAX   4'h9

`endif

// File: src/wdr_pkg.sv
// Types shared by the watchdog and reset-cause block.
package wdr_pkg;

    typedef enum logic [1:0] {
        WDR_STOP   = 2'b00,
        WDR_IRQ    = 2'b01,
        WDR_RESET  = 2'b10,
        WDR_IRQRST = 2'b11
    } wdr_mode_e;

    typedef logic [3:0] wdr_period_t;

endpackage

// File: src/wdr_counter.sv
// Watchdog time-out counter running on slow oscillator ticks.
`timescale 1ns/100ps
`default_nettype none
`include "wdr_cfg.svh"
module wdr_counter #(
    parameter int BASE_TICKS = `WDR_BASE_TICKS
) (
    input  wire logic                clk,
    input  wire logic                rst,
    input  wire logic                ce,
    input  wire logic                tick,
    input  wire logic                run,
    input  wire logic                restart,
    input  wire wdr_pkg::wdr_period_t period,
    output logic                     timeout
);
    import wdr_pkg::*;

    logic [19:0] cnt_r;
    logic [19:0] limit;
    wdr_period_t code;

    // Reserved codes behave as the longest period.
    always_comb begin
        code  = (period > `WDR_PERIOD_MAX) ? `WDR_PERIOD_MAX : period;
        limit = 20'((BASE_TICKS << code) - 1);
    end

    // A shorter period may already be passed; it fires at the next tick.
    assign timeout = ce & run & tick & (cnt_r >= limit);

    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_r <= 20'h00000;
        end else if (ce) begin
            if (!run || restart || timeout) begin
                cnt_r <= 20'h00000;
            end else if (tick) begin
                cnt_r <= cnt_r + 20'h00001;
            end
        end
    end

    property p_stop_clear;
        @(posedge clk) disable iff (rst)
        (ce && (!run || restart)) |=> (cnt_r == 20'h00000);
    endproperty
    a_stop_clear: assert property (p_stop_clear)
        else $error("Counter not cleared while stopped or restarted.");

    property p_wrap;
        @(posedge clk) disable iff (rst)
        timeout |-> (cnt_r == limit) || (cnt_r > limit);
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("Time-out fired before the period elapsed.");

endmodule // wdr_counter
`default_nettype wire

// File: src/wdr_unlock.sv
// Change-unlock window that closes itself after four cycles.
`timescale 1ns/100ps
`default_nettype none
`include "wdr_cfg.svh"
module wdr_unlock (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic ce,
    input  wire logic open,
    input  wire logic close,
    output logic      active
);
    import wdr_pkg::*;

    logic [1:0] left_r;

    // A second unlock inside the window does not stretch it.
    always_ff @(posedge clk) begin
        if (rst) begin
            active <= 1'b0;
            left_r <= 2'd0;
        end else if (ce) begin
            if (close) begin
                active <= 1'b0;
            end else if (open && !active) begin
                active <= 1'b1;
                left_r <= `WDR_UNLOCK_CYC;
            end else if (active) begin
                if (left_r == 2'd0) begin
                    active <= 1'b0;
                end else begin
                    left_r <= left_r - 2'd1;
                end
            end
        end
    end

    property p_unlock_len;
        @(posedge clk) disable iff (rst)
        ($rose(active) ##0 ce[*4]) |=> !active;
    endproperty
    a_unlock_len: assert property (p_unlock_len)
        else $error("Unlock window stayed open beyond four cycles.");

endmodule // wdr_unlock
`default_nettype wire

// File: src/wdr_top.sv
// Watchdog timer with its control register and reset-cause register.
`timescale 1ns/100ps
`default_nettype none
`include "wdr_cfg.svh"
module wdr_top #(
    parameter int BASE_TICKS = `WDR_BASE_TICKS
) (
    input  wire logic        REF_CLK,
    input  wire logic        RST,
    input  wire logic        CLK_EN,
    input  wire logic        WB_CYC_I,
    input  wire logic        WB_STB_I,
    input  wire logic        WB_WE_I,
    input  wire logic [7:0]  WB_ADR_I,
    input  wire logic [3:0]  WB_SEL_I,
    input  wire logic [31:0] WB_DAT_I,
    output logic             WB_ACK_O,
    output logic [31:0]      WB_DAT_O,
    input  wire logic        OSC_TICK,
    input  wire logic        RESTART_INSN,
    input  wire logic        CPU_STATUS_GLOBAL_IRQ,
    input  wire logic        IRQ_VECTOR_TAKEN,
    input  wire logic        ALWAYS_ON_FUSE,
    input  wire logic        POWERON_EVENT,
    input  wire logic        BROWNOUT_EVENT,
    input  wire logic        PIN_RESET_EVENT,
    output logic             TIMEOUT_IRQ,
    output logic             SYS_RESET
);
    import wdr_pkg::*;

    // ****************************************************************
    // Address decoding
    // ****************************************************************
    function automatic logic hit(input logic [7:0] adr,
                                 input logic [7:0] off);
        hit = (adr == off);
    endfunction

    logic        req;
    logic        ack_r;
    logic [31:0] dat_r;
    logic        wr_now;
    logic        wr_ctl;
    logic        wr_cause;
    logic [7:0]  wd;
    logic [7:0]  ctl_val;
    logic [7:0]  cause_val;
    logic [31:0] rd_val;

    // ****************************************************************
    // State
    // ****************************************************************
    logic        flag_r;
    logic        ie_r;
    logic        re_r;
    wdr_period_t period_r;
    logic [3:0]  cause_r;
    logic        sys_reset_r;
    logic        unlock;

    logic        fuse_on;
    logic        re_eff;
    logic        ie_eff;
    wdr_mode_e   mode;
    logic        timeout;
    logic        dog_fire;
    logic        flag_set;
    logic        any_rst;
    logic [3:0]  cause_set;
    logic [3:0]  cause_hwclr;

    localparam logic [3:0] CAUSE_RST = `WDR_CAUSE_RST;

    assign req = WB_CYC_I & WB_STB_I;
    assign wd  = WB_DAT_I[7:0];

    // The write lands on the edge that also samples ack, once per access.
    assign wr_now   = CLK_EN & req & WB_WE_I & ack_r & WB_SEL_I[0];
    assign wr_ctl   = wr_now & hit(WB_ADR_I, `WDR_ADR_CTL);
    assign wr_cause = wr_now & hit(WB_ADR_I, `WDR_ADR_CAUSE);

    // ****************************************************************
    // Mode selection
    // ****************************************************************
    // A programmed fuse reads as zero and locks the block in reset mode.
    assign fuse_on = ~ALWAYS_ON_FUSE;
    assign re_eff  = fuse_on | re_r | cause_r[`WDR_CAUSE_DOG];
    assign ie_eff  = ~fuse_on & ie_r;
    assign mode    = wdr_mode_e'({re_eff, ie_eff});

    // In combined mode an unserviced flag turns the next time-out into a
    // reset instead of a second interrupt.
    always_comb begin
        dog_fire = 1'b0;
        flag_set = 1'b0;
        case (mode)
            WDR_IRQ: begin
                flag_set = timeout;
            end
            WDR_RESET: begin
                dog_fire = timeout;
            end
            WDR_IRQRST: begin
                dog_fire = timeout & flag_r;
                flag_set = timeout & ~flag_r;
            end
            default: begin
                dog_fire = 1'b0;
                flag_set = 1'b0;
            end
        endcase
    end

    // Any reset source, the watchdog's own included, restores the control
    // register on the edge that records the cause, but its own reset sets re_r.
    assign any_rst = POWERON_EVENT | BROWNOUT_EVENT | PIN_RESET_EVENT |
                     sys_reset_r;

    // ****************************************************************
    // Counter and unlock window
    // ****************************************************************
    wdr_counter #(
        .BASE_TICKS (BASE_TICKS)
    ) u_counter (
        .clk     (REF_CLK),
        .rst     (RST),
        .ce      (CLK_EN),
        .tick    (OSC_TICK),
        .run     (mode != WDR_STOP),
        .restart (RESTART_INSN),
        .period  (period_r),
        .timeout (timeout)
    );

    wdr_unlock u_unlock (
        .clk    (REF_CLK),
        .rst    (RST),
        .ce     (CLK_EN),
        .open   (wr_ctl & wd[`WDR_CTL_UNLOCK]),
        .close  (any_rst | (wr_ctl & ~wd[`WDR_CTL_UNLOCK])),
        .active (unlock)
    );

    // ****************************************************************
    // Control register
    // ****************************************************************
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            flag_r <= 1'b0;
        end else if (CLK_EN) begin
            if (any_rst) begin
                flag_r <= 1'b0;
            end else if (flag_set) begin
                flag_r <= 1'b1;
            end else if (IRQ_VECTOR_TAKEN ||
                         (wr_ctl && wd[`WDR_CTL_FLAG])) begin
                flag_r <= 1'b0;
            end
        end
    end

    // The hardware clear on the vector beats a same-cycle write of one.
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            ie_r <= 1'b0;
        end else if (CLK_EN) begin
            if (any_rst) begin
                ie_r <= 1'b0;
            end else if (IRQ_VECTOR_TAKEN && mode == WDR_IRQRST) begin
                ie_r <= 1'b0;
            end else if (wr_ctl) begin
                ie_r <= wd[`WDR_CTL_IE];
            end
        end
    end

    // Setting reset enable is always allowed; clearing it is guarded.
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            re_r <= 1'b0;
        end else if (CLK_EN) begin
            if (sys_reset_r) begin
                re_r <= 1'b1;
            end else if (any_rst) begin
                re_r <= 1'b0;
            end else if (wr_ctl) begin
                if (wd[`WDR_CTL_RE]) begin
                    re_r <= 1'b1;
                end else if (unlock && !cause_r[`WDR_CAUSE_DOG]) begin
                    re_r <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            period_r <= 4'h0;
        end else if (CLK_EN) begin
            if (any_rst) begin
                period_r <= 4'h0;
            end else if (wr_ctl && unlock) begin
                period_r <= {wd[`WDR_CTL_P3], wd[2:0]};
            end
        end
    end

    // ****************************************************************
    // Reset pulse and interrupt request
    // ****************************************************************
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            sys_reset_r <= 1'b0;
        end else if (CLK_EN) begin
            sys_reset_r <= dog_fire;
        end
    end

    assign SYS_RESET   = sys_reset_r;
    assign TIMEOUT_IRQ = flag_r & ie_eff & CPU_STATUS_GLOBAL_IRQ;

    // ****************************************************************
    // Reset-cause register
    // ****************************************************************
    // A new cause beats a software clear in the same cycle.
    assign cause_set   = {sys_reset_r, BROWNOUT_EVENT, PIN_RESET_EVENT,
                          POWERON_EVENT};
    assign cause_hwclr = {POWERON_EVENT, POWERON_EVENT, POWERON_EVENT,
                          1'b0};

    for (genvar i = 0; i < 4; i++) begin : g_cause
        always_ff @(posedge REF_CLK) begin
            if (RST) begin
                cause_r[i] <= CAUSE_RST[i];
            end else if (CLK_EN) begin
                if (cause_set[i]) begin
                    cause_r[i] <= 1'b1;
                end else if (cause_hwclr[i] || (wr_cause && !wd[i])) begin
                    cause_r[i] <= 1'b0;
                end
            end
        end
    end

    // ****************************************************************
    // Wishbone slave
    // ****************************************************************
    assign ctl_val   = {flag_r, ie_eff, period_r[3], unlock, re_eff,
                        period_r[2:0]};
    assign cause_val = {4'h0, cause_r};

    always_comb begin
        if (hit(WB_ADR_I, `WDR_ADR_CTL)) begin
            rd_val = {24'h000000, ctl_val};
        end else if (hit(WB_ADR_I, `WDR_ADR_CAUSE)) begin
            rd_val = {24'h000000, cause_val};
        end else begin
            rd_val = 32'h00000000;
        end
    end

    // Every access, mapped or not, is acknowledged one cycle after it
    // starts; unmapped reads return zero and unmapped writes vanish.
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            ack_r <= 1'b0;
            dat_r <= 32'h00000000;
        end else if (CLK_EN) begin
            ack_r <= req & ~ack_r;
            if (req && !ack_r && !WB_WE_I) begin
                dat_r <= rd_val;
            end else begin
                dat_r <= 32'h00000000;
            end
        end
    end

    assign WB_ACK_O = ack_r;
    assign WB_DAT_O = dat_r;

    // ****************************************************************
    // Checks
    // ****************************************************************
    property p_cause_upper;
        @(posedge REF_CLK) disable iff (RST)
        (WB_ACK_O && !WB_WE_I && hit(WB_ADR_I, `WDR_ADR_CAUSE))
            |-> (WB_DAT_O[31:4] == 28'h0000000);
    endproperty
    a_cause_upper: assert property (p_cause_upper)
        else $error("Unused cause bits read as non-zero.");

    property p_dog_cause;
        @(posedge REF_CLK) disable iff (RST)
        (CLK_EN && SYS_RESET) |=> cause_r[`WDR_CAUSE_DOG] ##0 re_eff;
    endproperty
    a_dog_cause: assert property (p_dog_cause)
        else $error("Watchdog reset did not record its cause.");

    property p_bor_cause;
        @(posedge REF_CLK) disable iff (RST)
        (CLK_EN && BROWNOUT_EVENT) |=> cause_r[`WDR_CAUSE_BOR];
    endproperty
    a_bor_cause: assert property (p_bor_cause)
        else $error("Brown-out did not record its cause.");

    property p_por_sticky;
        @(posedge REF_CLK) disable iff (RST)
        $fell(cause_r[`WDR_CAUSE_POR]) |-> $past(wr_cause && !wd[0]);
    endproperty
    a_por_sticky: assert property (p_por_sticky)
        else $error("Power-on cause cleared without a software write.");

    property p_re_forced;
        @(posedge REF_CLK) disable iff (RST)
        cause_r[`WDR_CAUSE_DOG] |-> ctl_val[`WDR_CTL_RE];
    endproperty
    a_re_forced: assert property (p_re_forced)
        else $error("Reset enable reads zero while the cause is set.");

    property p_period_locked;
        @(posedge REF_CLK) disable iff (RST)
        (CLK_EN && !unlock && !any_rst) |=> $stable(period_r);
    endproperty
    a_period_locked: assert property (p_period_locked)
        else $error("Period changed outside the unlock window.");

    property p_pulse_one;
        @(posedge REF_CLK) disable iff (RST)
        $rose(SYS_RESET) |=> !SYS_RESET ##1 !SYS_RESET;
    endproperty
    a_pulse_one: assert property (p_pulse_one)
        else $error("Watchdog reset pulse longer than one cycle.");

    property p_second_timeout;
        @(posedge REF_CLK) disable iff (RST)
        (timeout && mode == WDR_IRQRST && flag_r) |=> SYS_RESET;
    endproperty
    a_second_timeout: assert property (p_second_timeout)
        else $error("Unserviced interrupt did not lead to a reset.");

    property p_vector_clear;
        @(posedge REF_CLK) disable iff (RST)
        (CLK_EN && IRQ_VECTOR_TAKEN && mode == WDR_IRQRST && !timeout &&
         !any_rst) |=> (!ie_r && !flag_r);
    endproperty
    a_vector_clear: assert property (p_vector_clear)
        else $error("Vector did not drop enable and flag.");

    property p_irq_gate;
        @(posedge REF_CLK) disable iff (RST)
        TIMEOUT_IRQ |-> (ctl_val[7:6] == 2'b11) && CPU_STATUS_GLOBAL_IRQ;
    endproperty
    a_irq_gate: assert property (p_irq_gate)
        else $error("Interrupt requested without both enables.");

endmodule // wdr_top
`default_nettype wire

// File: testbench/wdr_top_tb_top.sv
// Self-checking bench of the watchdog and reset-cause block.
`timescale 1ns/100ps
`default_nettype none
`include "wdr_cfg.svh"
module wdr_top_tb_top;
    import wdr_pkg::*;
    logic        ref_clk = 1'h0;
    logic        rst = 1'h1;
    logic        req = 1'h0;
    logic        we = 1'h0;
    logic [7:0]  adr = 8'h00;
    logic [31:0] dat = 32'h0;
    logic [31:0] rdat;
    logic [7:0]  rv;
    logic [4:0]  evs = 5'h00;
    logic        tck = 1'h0;
    logic        gie = 1'h0;
    logic        fuse = 1'h1;
    logic        ack;
    logic        irq;
    logic        sysr;
    int          error_cnt = 0;
    int          samples_checked = 0;
    int          rst_seen = 0;

    always #5 ref_clk = ~ref_clk;

    // Each high sample is one cycle of reset pulse, so one watchdog
    // reset must add exactly one.
    always @(posedge ref_clk) begin
        if (sysr === 1'h1) begin
            rst_seen <= rst_seen + 1;
        end
    end

    wdr_top #(.BASE_TICKS(4)) DUT (
        .REF_CLK              (ref_clk),
        .RST                  (rst),
        .CLK_EN               (1'h1),
        .WB_CYC_I             (req),
        .WB_STB_I             (req),
        .WB_WE_I              (we),
        .WB_ADR_I             (adr),
        .WB_SEL_I             (4'hf),
        .WB_DAT_I             (dat),
        .WB_ACK_O             (ack),
        .WB_DAT_O             (rdat),
        .OSC_TICK             (tck),
        .RESTART_INSN         (evs[3]),
        .CPU_STATUS_GLOBAL_IRQ(gie),
        .IRQ_VECTOR_TAKEN     (evs[4]),
        .ALWAYS_ON_FUSE       (fuse),
        .POWERON_EVENT        (evs[0]),
        .BROWNOUT_EVENT       (evs[1]),
        .PIN_RESET_EVENT      (evs[2]),
        .TIMEOUT_IRQ          (irq),
        .SYS_RESET            (sysr)
    );

    // ********************
    // Helper tasks
    // ********************
    task automatic chk(input string nm, input logic [7:0] e,
                       input logic [7:0] g);
        samples_checked++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [7:0] d);
        req <= 1'h1;
        we <= w;
        adr <= a;
        dat <= {24'h0, d};
        do begin
            @(posedge ref_clk);
        end while (ack !== 1'h1);
        rv = rdat[7:0];
        req <= 1'h0;
        we <= 1'h0;
        @(posedge ref_clk);
        // The slave must drop its ack in the cycle after it gave it.
        chk("ack", 8'h00, {7'h0, ack});
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        wb(1'h1, a, d);
    endtask

    task automatic rd(input string nm, input logic [7:0] a,
                      input logic [7:0] e);
        wb(1'h0, a, 8'h00);
        chk(nm, e, rv);
    endtask

    task automatic cfg(input logic [7:0] d);
        wr(`WDR_ADR_CTL, 8'h18);
        wr(`WDR_ADR_CTL, d);
    endtask

    task automatic pulse(input int b);
        evs[b] <= 1'h1;
        @(posedge ref_clk);
        evs <= 5'h00;
        @(posedge ref_clk);
    endtask

    task automatic tick(input int n);
        repeat (n) begin
            tck <= 1'h1;
            @(posedge ref_clk);
            tck <= 1'h0;
            @(posedge ref_clk);
        end
    endtask

    // ********************
    // Scenarios
    // ********************
    task automatic t_regs;
        rd("ctl", `WDR_ADR_CTL, 8'h00);
        rd("cause", `WDR_ADR_CAUSE, 8'h00);
        wr(8'h70, 8'hff);
        rd("unmapped", 8'h70, 8'h00);
        $display("test regs done");
    endtask

    task automatic t_cause;
        pulse(0);
        rd("cause", `WDR_ADR_CAUSE, 8'h01);
        pulse(1);
        rd("cause", `WDR_ADR_CAUSE, 8'h05);
        pulse(2);
        rd("cause", `WDR_ADR_CAUSE, 8'h07);
        wr(`WDR_ADR_CAUSE, 8'hff);
        rd("cause", `WDR_ADR_CAUSE, 8'h07);
        wr(`WDR_ADR_CAUSE, 8'h00);
        rd("cause", `WDR_ADR_CAUSE, 8'h00);
        pulse(1);
        pulse(2);
        pulse(0);
        rd("cause", `WDR_ADR_CAUSE, 8'h01);
        wr(`WDR_ADR_CAUSE, 8'h00);
        $display("test cause done");
    endtask

    task automatic t_unlock;
        wr(`WDR_ADR_CTL, 8'h07);
        rd("ctl", `WDR_ADR_CTL, 8'h00);
        cfg(8'h29);
        rd("ctl", `WDR_ADR_CTL, 8'h29);
        wr(`WDR_ADR_CTL, 8'h20);
        rd("ctl", `WDR_ADR_CTL, 8'h29);
        wr(`WDR_ADR_CTL, 8'h39);
        rd("ctl", `WDR_ADR_CTL, 8'h39);
        repeat (2) @(posedge ref_clk);
        rd("ctl", `WDR_ADR_CTL, 8'h29);
        wr(`WDR_ADR_CTL, 8'h00);
        rd("ctl", `WDR_ADR_CTL, 8'h29);
        cfg(8'h00);
        rd("ctl", `WDR_ADR_CTL, 8'h00);
        $display("test unlock done");
    endtask

    task automatic t_irq;
        cfg(8'h40);
        pulse(3);
        tick(3);
        pulse(3);
        tick(3);
        rd("ctl", `WDR_ADR_CTL, 8'h40);
        tick(1);
        rd("ctl", `WDR_ADR_CTL, 8'hc0);
        chk("irq", 8'h00, {7'h0, irq});
        gie <= 1'h1;
        @(posedge ref_clk);
        chk("irq", 8'h01, {7'h0, irq});
        wr(`WDR_ADR_CTL, 8'hc0);
        rd("ctl", `WDR_ADR_CTL, 8'h40);
        chk("irq", 8'h00, {7'h0, irq});
        pulse(3);
        cfg(8'h41);
        tick(7);
        rd("ctl", `WDR_ADR_CTL, 8'h41);
        tick(1);
        rd("ctl", `WDR_ADR_CTL, 8'hc1);
        wr(`WDR_ADR_CTL, 8'hc1);
        pulse(3);
        cfg(8'h6f);
        // A reserved code runs the longest period, 4 << 9 ticks.
        tick(2047);
        rd("ctl", `WDR_ADR_CTL, 8'h6f);
        tick(1);
        rd("ctl", `WDR_ADR_CTL, 8'hef);
        wr(`WDR_ADR_CTL, 8'hef);
        cfg(8'h00);
        gie <= 1'h0;
        chk("resets", 8'h00, 8'(rst_seen));
        $display("test irq done");
    endtask

    task automatic t_rst;
        int rs;
        rs = rst_seen;
        cfg(8'h48);
        pulse(3);
        tick(4);
        rd("ctl", `WDR_ADR_CTL, 8'hc8);
        chk("resets", 8'h00, 8'(rst_seen - rs));
        pulse(4);
        rd("ctl", `WDR_ADR_CTL, 8'h08);
        tick(4);
        rd("cause", `WDR_ADR_CAUSE, 8'h08);
        chk("resets", 8'h01, 8'(rst_seen - rs));
        rd("ctl", `WDR_ADR_CTL, 8'h08);
        cfg(8'h00);
        rd("ctl", `WDR_ADR_CTL, 8'h08);
        wr(`WDR_ADR_CAUSE, 8'h00);
        cfg(8'h48);
        pulse(3);
        tick(8);
        rd("cause", `WDR_ADR_CAUSE, 8'h08);
        chk("resets", 8'h02, 8'(rst_seen - rs));
        wr(`WDR_ADR_CAUSE, 8'h00);
        cfg(8'h00);
        rd("ctl", `WDR_ADR_CTL, 8'h00);
        $display("test reset done");
    endtask

    task automatic t_fuse;
        int rs;
        rs = rst_seen;
        fuse <= 1'h0;
        @(posedge ref_clk);
        rd("ctl", `WDR_ADR_CTL, 8'h08);
        wr(`WDR_ADR_CTL, 8'h40);
        rd("ctl", `WDR_ADR_CTL, 8'h08);
        pulse(3);
        tick(4);
        rd("cause", `WDR_ADR_CAUSE, 8'h08);
        chk("resets", 8'h01, 8'(rst_seen - rs));
        wr(`WDR_ADR_CAUSE, 8'h00);
        fuse <= 1'h1;
        cfg(8'h00);
        rd("ctl", `WDR_ADR_CTL, 8'h00);
        $display("test fuse done");
    endtask

    initial begin
        #200000;
        error_cnt++;
        report_and_stop();
    end

    initial begin
        repeat (20) @(posedge ref_clk);
        rst <= 1'h0;
        @(posedge ref_clk);
        t_regs();
        t_cause();
        t_unlock();
        t_irq();
        t_rst();
        t_fuse();
        report_and_stop();
    end
endmodule // wdr_top_tb_top
`default_nettype wire
